// ---- common/pmr_pkg.sv ----
// pmr_pkg: constants for the power monitor readback and alert block
// assumes a 125 MHz core clock and a byte-level two-wire slave engine outside
// Function
// R1 - force-off deasserts alert output only while off-alert enable is set
// R2 - both channels: read gives V[11:4], I[11:4], then V[3:0] and I[3:0]
// R3 - voltage only: read gives V[11:4] then V[3:0] with low nibble zero
// R4 - current only: read gives I[11:4] then I[3:0] with low nibble zero
// R5 - master acks bytes one and two, nacks byte three, then stops
// R6 - single channel reads: master takes two bytes, nacks second, then stops
// R7 - status select makes an addressed read return one status byte
// R8 - status bit 0 set while last three current conversions exceeded threshold
// R9 - status bit 1 latches on adc trip alert, cleared by alert-enable bit 4
// R10 - status bit 2 follows live comparator overcurrent, no latching
// R11 - status bit 3 latches comparator fault alert, cleared by alert-enable bit 4
// R12 - status bit 4 reads one after force-off bit written high
// R13 - status bit 5 latches force-off alert, cleared by alert-enable bit 4
// R14 - alert pin driven low normally, released high on fault
// R15 - comparator assertion starts delay timer; alert only after delay completes
// R16 - voltage codes are 12-bit unsigned, step full scale over 4096
// R17 - clear bit resets latched trip flags then returns to zero itself
// R18 - extended write address has msb one, two lsbs select, 3 is control
// R19 - status-select command bit makes later reads return status byte
// R20 - fault delay is a counter with terminal count, restarts on deassert
// R21 - read byte index returns to first byte at every start condition
package pmr_pkg;
  localparam int unsigned CORE_CLK_MHZ = 125;
  // fault delay stands in for the timer capacitor charge time
  localparam int unsigned FAULT_DELAY_US = 10;
  localparam int unsigned FAULT_DELAY_CYCLES = FAULT_DELAY_US * CORE_CLK_MHZ;
  // full scale in millivolts per range, code step is full scale / 4096
  localparam int unsigned VFS_RANGE_72_MV = 6650;
  localparam int unsigned VFS_RANGE_141_MV = 26520;
  localparam int unsigned ADC_CODES = 4096;
  localparam int unsigned ADC_BITS = 12;
  // command byte fields
  localparam int unsigned CMD_V_CONT = 0;
  localparam int unsigned CMD_V_ONCE = 1;
  localparam int unsigned CMD_I_CONT = 2;
  localparam int unsigned CMD_I_ONCE = 3;
  localparam int unsigned CMD_VOLTAGE_RANGE_SELECT = 4;
  localparam int unsigned CMD_STATUS_RD = 6;
  localparam int unsigned CMD_EXT_FLAG = 7;
  // extended register selects
  localparam logic [1:0] EXT_ALERT_EN = 2'h1;
  localparam logic [1:0] EXT_ALERT_TH = 2'h2;
  localparam logic [1:0] EXT_CONTROL = 2'h3;
  // alert enable fields and reset value
  localparam int unsigned AEN_ADC_OC1 = 0;
  localparam int unsigned AEN_ADC_OC4 = 1;
  localparam int unsigned AEN_COMPARATOR_TRIP_LATCHED = 2;
  localparam int unsigned AEN_OFF_ALERT = 3;
  localparam int unsigned AEN_CLEAR = 4;
  localparam logic [7:0] ALERT_EN_RESET = 8'h04;
  localparam logic [7:0] ALERT_TH_RESET = 8'hFF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam int unsigned CTL_FORCE_OFF = 0;
  // status byte fields
  localparam int unsigned ST_ADC_LIVE = 0;
  localparam int unsigned ST_ADC_TRIP = 1;
  localparam int unsigned ST_COMP_LIVE = 2;
  localparam int unsigned ST_COMP_TRIP = 3;
  localparam int unsigned ST_OFF_STATUS = 4;
  localparam int unsigned ST_OFF_TRIP = 5;
  // byte returned past the end of a reply
  localparam logic [7:0] RD_PAD = 8'h00;
  // write sequence states
  typedef enum logic [1:0] {PMR_WR_IDLE, PMR_WR_EXT, PMR_WR_DONE} pmr_wr_e;
endpackage

// ---- common/pmr_timer_if.sv ----
// pmr_timer_if: link between the alert logic and its fault delay counter
// assumes both ends run on core_clk
`timescale 1ns/10ps
`default_nettype none
interface pmr_timer_if;
  logic fault_level;
  logic expired;
  modport owner (output fault_level, input expired);
  modport timer (input fault_level, output expired);
endinterface
`default_nettype wire

// ---- hdl/pmr_fault_timer.sv ----
// pmr_fault_timer: counts while the fault level holds, flags expiry
// assumes a synchronous active high reset on core_clk
`timescale 1ns/10ps
`default_nettype none
module pmr_fault_timer #(
  parameter int unsigned TERMINAL = pmr_pkg::FAULT_DELAY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  pmr_timer_if.timer tmr
);
  localparam int unsigned CW = $clog2(TERMINAL + 1);
  localparam logic [CW-1:0] TERM = CW'(TERMINAL);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic exp_q;
  logic exp_d;

  // ==========================================================
  // delay counter
  // restart on any drop of the fault before expiry
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!tmr.fault_level) begin
      cnt_d = '0; // R20
    end else if (cnt_q < TERM) begin
      cnt_d = cnt_q + CW'(1); // R15
    end
    if (tmr.fault_level && cnt_q >= TERM) begin
      exp_d = 1'b1; // R15
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign tmr.expired = exp_q;
endmodule
`default_nettype wire

// ---- hdl/pmr_readback_alert.sv ----
// pmr_readback_alert: read reply packing, status byte and alert pin logic
// assumes a byte-level two-wire slave engine on core_clk and adc results on core_clk
`timescale 1ns/10ps
`default_nettype none
module pmr_readback_alert #(
  parameter int unsigned FAULT_DELAY_CYCLES = pmr_pkg::FAULT_DELAY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic bus_start,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic adc_v_valid,
  input wire logic [11:0] adc_v_code,
  input wire logic adc_i_valid,
  input wire logic [11:0] adc_i_code,
  input wire logic adc_i_over,
  input wire logic comparator_overcurrent,
  output logic alert_o,
  output logic alert_oe,
  output logic voltage_range_select,
  output logic [7:0] alert_threshold
);
  // ==========================================================
  // registers
  logic [7:0] command_q, command_d;
  logic [7:0] alert_en_q, alert_en_d;
  logic [7:0] alert_th_q, alert_th_d;
  logic [7:0] control_q, control_d;
  logic [1:0] ext_sel_q, ext_sel_d;
  pmr_pkg::pmr_wr_e wr_st_q, wr_st_d;
  logic [11:0] volt_q, volt_d;
  logic [11:0] curr_q, curr_d;
  logic [2:0] over_hist_q, over_hist_d;
  logic adc_trip_q, adc_trip_d;
  logic comp_trip_q, comp_trip_d;
  logic off_trip_q, off_trip_d;
  logic [1:0] rd_idx_q, rd_idx_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic alert_oe_q, alert_oe_d;
  logic [2:0] comp_sync_q;
  logic comp_live_q, comp_live_d;
  logic adc_event;
  logic [7:0] status_byte;
  logic v_sel;
  logic i_sel;
  logic fault_any;
  logic force_low;

  pmr_timer_if tmr_if ();

  // ==========================================================
  // comparator pin synchroniser, change taken once stages two and three agree
  always_comb begin
    comp_live_d = comp_live_q;
    if (comp_sync_q[1] == comp_sync_q[2]) begin
      comp_live_d = comp_sync_q[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      comp_sync_q <= 3'h0;
      comp_live_q <= 1'b0;
    end else begin
      comp_sync_q <= {comp_sync_q[1:0], comparator_overcurrent};
      comp_live_q <= comp_live_d;
    end
  end

  // ==========================================================
  // fault delay timer
  assign tmr_if.fault_level = comp_live_q; // R15

  pmr_fault_timer #(
    .TERMINAL(FAULT_DELAY_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .tmr(tmr_if.timer)
  );

  // ==========================================================
  // write path: command byte or extended address then data
  always_comb begin
    wr_st_d = wr_st_q;
    ext_sel_d = ext_sel_q;
    command_d = command_q;
    alert_en_d = alert_en_q;
    alert_th_d = alert_th_q;
    control_d = control_q;
    if (alert_en_q[pmr_pkg::AEN_CLEAR]) begin
      alert_en_d[pmr_pkg::AEN_CLEAR] = 1'b0; // R17
    end
    if (bus_start) begin
      wr_st_d = pmr_pkg::PMR_WR_IDLE;
    end else if (wr_valid) begin
      case (wr_st_q)
        pmr_pkg::PMR_WR_IDLE: begin
          if (wr_data[pmr_pkg::CMD_EXT_FLAG]) begin
            ext_sel_d = wr_data[1:0]; // R18
            wr_st_d = pmr_pkg::PMR_WR_EXT;
          end else begin
            command_d = wr_data; // R19
            wr_st_d = pmr_pkg::PMR_WR_DONE;
          end
        end
        pmr_pkg::PMR_WR_EXT: begin
          case (ext_sel_q)
            pmr_pkg::EXT_ALERT_EN: alert_en_d = wr_data;
            pmr_pkg::EXT_ALERT_TH: alert_th_d = wr_data;
            pmr_pkg::EXT_CONTROL: control_d = wr_data; // R18
            default: control_d = control_q;
          endcase
          wr_st_d = pmr_pkg::PMR_WR_DONE;
        end
        default: wr_st_d = pmr_pkg::PMR_WR_DONE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_st_q <= pmr_pkg::PMR_WR_IDLE;
      ext_sel_q <= 2'h0;
      command_q <= pmr_pkg::COMMAND_RESET;
      alert_en_q <= pmr_pkg::ALERT_EN_RESET;
      alert_th_q <= pmr_pkg::ALERT_TH_RESET;
      control_q <= pmr_pkg::CONTROL_RESET;
    end else begin
      wr_st_q <= wr_st_d;
      ext_sel_q <= ext_sel_d;
      command_q <= command_d;
      alert_en_q <= alert_en_d;
      alert_th_q <= alert_th_d;
      control_q <= control_d;
    end
  end

  // ==========================================================
  // conversion capture and trip flags
  assign adc_event = adc_i_valid && adc_i_over;
  assign force_low = control_q[pmr_pkg::CTL_FORCE_OFF] && alert_en_q[pmr_pkg::AEN_OFF_ALERT];

  always_comb begin
    volt_d = volt_q;
    curr_d = curr_q;
    over_hist_d = over_hist_q;
    adc_trip_d = adc_trip_q;
    comp_trip_d = comp_trip_q;
    off_trip_d = off_trip_q;
    if (adc_v_valid) begin
      volt_d = adc_v_code; // R16
    end
    if (adc_i_valid) begin
      curr_d = adc_i_code;
      over_hist_d = {over_hist_q[1:0], adc_i_over};
    end
    // clear first, so a same-cycle event below wins
    if (alert_en_q[pmr_pkg::AEN_CLEAR]) begin
      adc_trip_d = 1'b0; // R9
      comp_trip_d = 1'b0; // R11
      off_trip_d = 1'b0; // R13
    end
    if ((adc_event && alert_en_q[pmr_pkg::AEN_ADC_OC1]) ||
        (adc_event && over_hist_q[2:0] == 3'h7 && alert_en_q[pmr_pkg::AEN_ADC_OC4])) begin
      adc_trip_d = 1'b1; // R9
    end
    if (tmr_if.expired && alert_en_q[pmr_pkg::AEN_COMPARATOR_TRIP_LATCHED]) begin
      comp_trip_d = 1'b1; // R11
    end
    if (force_low) begin
      off_trip_d = 1'b1; // R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      volt_q <= 12'h000;
      curr_q <= 12'h000;
      over_hist_q <= 3'h0;
      adc_trip_q <= 1'b0;
      comp_trip_q <= 1'b0;
      off_trip_q <= 1'b0;
    end else begin
      volt_q <= volt_d;
      curr_q <= curr_d;
      over_hist_q <= over_hist_d;
      adc_trip_q <= adc_trip_d;
      comp_trip_q <= comp_trip_d;
      off_trip_q <= off_trip_d;
    end
  end

  // ==========================================================
  // status byte
  always_comb begin
    status_byte = 8'h00;
    status_byte[pmr_pkg::ST_ADC_LIVE] = (over_hist_q[2:0] == 3'h7); // R8
    status_byte[pmr_pkg::ST_ADC_TRIP] = adc_trip_q; // R9
    status_byte[pmr_pkg::ST_COMP_LIVE] = comp_live_q; // R10
    status_byte[pmr_pkg::ST_COMP_TRIP] = comp_trip_q; // R11
    status_byte[pmr_pkg::ST_OFF_STATUS] = control_q[pmr_pkg::CTL_FORCE_OFF]; // R12
    status_byte[pmr_pkg::ST_OFF_TRIP] = off_trip_q; // R13
  end

  // ==========================================================
  // read reply packing
  assign v_sel = command_q[pmr_pkg::CMD_V_CONT] || command_q[pmr_pkg::CMD_V_ONCE];
  assign i_sel = command_q[pmr_pkg::CMD_I_CONT] || command_q[pmr_pkg::CMD_I_ONCE];

  always_comb begin
    rd_idx_d = rd_idx_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    if (bus_start) begin
      rd_idx_d = 2'h0; // R21
    end else if (rd_req) begin
      rd_valid_d = 1'b1;
      if (rd_idx_q != 2'h3) begin
        rd_idx_d = rd_idx_q + 2'h1;
      end
      rd_data_d = pmr_pkg::RD_PAD;
      if (command_q[pmr_pkg::CMD_STATUS_RD]) begin
        if (rd_idx_q == 2'h0) begin
          rd_data_d = status_byte; // R7 R19
        end
      end else if (v_sel && !i_sel) begin
        case (rd_idx_q)
          2'h0: rd_data_d = volt_q[11:4]; // R3
          2'h1: rd_data_d = {volt_q[3:0], 4'h0}; // R3
          default: rd_data_d = pmr_pkg::RD_PAD;
        endcase
      end else if (i_sel && !v_sel) begin
        case (rd_idx_q)
          2'h0: rd_data_d = curr_q[11:4]; // R4
          2'h1: rd_data_d = {curr_q[3:0], 4'h0}; // R4
          default: rd_data_d = pmr_pkg::RD_PAD;
        endcase
      end else begin
        case (rd_idx_q)
          2'h0: rd_data_d = volt_q[11:4]; // R2
          2'h1: rd_data_d = curr_q[11:4]; // R2
          2'h2: rd_data_d = {volt_q[3:0], curr_q[3:0]}; // R2
          default: rd_data_d = pmr_pkg::RD_PAD;
        endcase
      end
    end
  end

  // ==========================================================
  // alert pin: driven low normally, released on fault unless forced off with off-alert enabled
  assign fault_any = adc_trip_q || comp_trip_q;

  always_comb begin
    alert_oe_d = 1'b1; // R14
    if (fault_any && !force_low) begin
      alert_oe_d = 1'b0; // R14
    end
    if (force_low) begin
      alert_oe_d = 1'b1; // R1
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_idx_q <= 2'h0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      alert_oe_q <= 1'b1;
    end else begin
      rd_idx_q <= rd_idx_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      alert_oe_q <= alert_oe_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign alert_oe = alert_oe_q;
  assign alert_o = 1'b0; // open drain, only ever pulls low
  assign voltage_range_select = command_q[pmr_pkg::CMD_VOLTAGE_RANGE_SELECT];
  assign alert_threshold = alert_th_q;
endmodule
`default_nettype wire

// ---- verification/pmr_readback_alert_sva.sv ----
// checker: port-level timing of the readback and alert outputs
// assumes one core_clk domain and a synchronous active high rst
`timescale 1ns/10ps
`default_nettype none
module pmr_readback_alert_sva #(
  parameter int unsigned FAULT_DELAY_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic bus_start,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic adc_i_valid,
  input wire logic adc_i_over,
  input wire logic comparator_overcurrent,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic voltage_range_select,
  input wire logic [7:0] alert_threshold
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // helper counters
  int unsigned comp_hi_q;
  int unsigned comp_hi_d;
  logic [3:0] cause_q;
  logic [3:0] cause_d;
  // pin run length, and a window after anything that may pull the alert
  always_comb begin
    comp_hi_d = (rst || !comparator_overcurrent) ? 0 : comp_hi_q + 1;
    cause_d = (cause_q != 4'h0) ? cause_q - 4'h1 : 4'h0;
    if (wr_valid || (adc_i_valid && adc_i_over) || comp_hi_q >= FAULT_DELAY_CYCLES) begin
      cause_d = 4'hF;
    end
    if (rst) begin
      cause_d = 4'h0;
    end
  end
  // registers only
  always_ff @(posedge core_clk) begin
    comp_hi_q <= comp_hi_d;
    cause_q <= cause_d;
  end
  // ==========================================================
  // properties
  property p_reset_vals;
    disable iff (1'b0) rst |=> alert_oe && alert_threshold == 8'hFF && !voltage_range_select
      && !rd_valid && rd_data == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs wrong after reset");
  property p_rd_answer;
    rd_req && !bus_start |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read byte not answered");
  property p_rd_cause;
    rd_valid |-> $past(rd_req) && !$past(bus_start);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read byte without request");
  property p_rd_hold;
    !rd_valid && !$past(rst) |-> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved unasked");
  property p_pin_low;
    alert_o == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("alert pin driven high");
  property p_thresh_wr;
    bus_start ##1 (!wr_valid && !bus_start) ##1 (wr_valid && wr_data == 8'h82 && !bus_start)
      ##1 (!wr_valid && !bus_start) ##1 (wr_valid && !bus_start)
      |=> alert_threshold == $past(wr_data);
  endproperty
  a_thresh_wr: assert property (p_thresh_wr) else $error("threshold write lost");
  property p_range_wr;
    bus_start ##1 (!wr_valid && !bus_start) ##1 (wr_valid && !wr_data[7] && !bus_start)
      |=> voltage_range_select == $past(wr_data[4]);
  endproperty
  a_range_wr: assert property (p_range_wr) else $error("range bit not taken");
  property p_alert_delay;
    $fell(alert_oe) |-> cause_q != 4'h0;
  endproperty
  a_alert_delay: assert property (p_alert_delay) else $error("alert before delay");
  c_read: cover property (rd_valid ##1 rd_valid);
  c_alert: cover property ($fell(alert_oe));
  c_release: cover property ($rose(alert_oe));
endmodule

bind pmr_readback_alert pmr_readback_alert_sva #(.FAULT_DELAY_CYCLES(FAULT_DELAY_CYCLES)) u_sva (
  .core_clk, .rst, .bus_start, .wr_valid, .wr_data, .rd_req, .rd_data, .rd_valid, .adc_i_valid,
  .adc_i_over, .comparator_overcurrent, .alert_o, .alert_oe, .voltage_range_select,
  .alert_threshold);
`default_nettype wire

// ---- verification/pmr_master_model.sv ----
// pmr_master_model: byte-level two-wire bus master driving the slave engine side
// assumes requests launch 1 ns after a core_clk rising edge
`timescale 1ns/10ps
`default_nettype none
module pmr_master_model (
  input wire logic core_clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic bus_start,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req
);
  // idle levels
  initial begin
    bus_start = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_req = 1'b0;
  end
  // start condition pulse
  task automatic start_cond();
    @(posedge core_clk) #1 bus_start = 1'b1;
    @(posedge core_clk) #1 bus_start = 1'b0;
  endtask
  // one written byte, data line scrambled once released
  task automatic put_byte(input logic [7:0] d);
    @(posedge core_clk) #1 wr_valid = 1'b1;
    wr_data = d;
    @(posedge core_clk) #1 wr_valid = 1'b0;
    wr_data = ~d;
  endtask
  // extended write: address byte with msb set, then data
  task automatic ext_write(input logic [1:0] sel, input logic [7:0] d);
    start_cond();
    put_byte({6'h20, sel});
    put_byte(d);
  endtask
  // one read byte, sometimes after a stall
  task automatic get_byte(output logic [7:0] b);
    repeat ($urandom_range(2)) @(posedge core_clk);
    @(posedge core_clk) #1 rd_req = 1'b1;
    @(posedge core_clk) #1 rd_req = 1'b0;
    b = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask
endmodule
`default_nettype wire

// ---- verification/pmr_readback_alert_test.sv ----
// testbench: reply packing, status byte and alert pin of the readback block
// assumes the byte-level master model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module pmr_readback_alert_test;
  localparam int unsigned FD = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  wire logic bus_start, wr_valid, rd_req;
  wire logic [7:0] wr_data;
  logic [7:0] rd_data, alert_threshold, b, r, cmd;
  logic rd_valid, alert_o, alert_oe, voltage_range_select;
  logic adc_v_valid = 1'b0, adc_i_valid = 1'b0, adc_i_over = 1'b0;
  logic comparator_overcurrent = 1'b0;
  logic [11:0] adc_v_code = 12'h000, adc_i_code = 12'h000, v, c;
  logic [7:0] modes [4] = '{8'h00, 8'h05, 8'h01, 8'h04};
  int fails = 0, samples_checked = 0, m;
  // ==========================================================
  // clock, design and far side
  always #4 core_clk = ~core_clk;
  pmr_readback_alert #(.FAULT_DELAY_CYCLES(FD)) DUT (.core_clk, .rst, .bus_start, .wr_valid,
    .wr_data, .rd_req, .rd_data, .rd_valid, .adc_v_valid, .adc_v_code, .adc_i_valid, .adc_i_code,
    .adc_i_over, .comparator_overcurrent, .alert_o, .alert_oe, .voltage_range_select,
    .alert_threshold);
  pmr_master_model u_master (.core_clk, .rd_data, .rd_valid, .bus_start, .wr_valid, .wr_data,
    .rd_req);
  // ==========================================================
  // helpers
  function automatic logic [7:0] exp_byte(int md, int k, logic [11:0] vv, logic [11:0] cc);
    if (md == 1) return k == 0 ? vv[11:4] : {vv[3:0], 4'h0};
    if (md == 2) return k == 0 ? cc[11:4] : {cc[3:0], 4'h0};
    return k == 0 ? vv[11:4] : k == 1 ? cc[11:4] : {vv[3:0], cc[3:0]};
  endfunction
  task automatic check(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmd_wr(logic [7:0] x);
    cmd = x;
    u_master.start_cond();
    u_master.put_byte(x);
  endtask
  task automatic adc(logic ov);
    adc_v_code = v;
    adc_i_code = c;
    adc_i_over = ov;
    adc_v_valid = 1'b1;
    adc_i_valid = 1'b1;
    tick(1);
    adc_v_valid = 1'b0;
    adc_i_valid = 1'b0;
    tick(1); // an edge passes before the next pulse
  endtask
  task automatic st_chk(logic [7:0] e);
    cmd_wr(8'h40);
    u_master.start_cond();
    u_master.get_byte(b);
    check(b, e);
    u_master.get_byte(b);
    check(b, pmr_pkg::RD_PAD);
  endtask
  task automatic finish_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(77084));
    tick(4);
    rst = 1'b0;
    check(alert_threshold, 8'hFF);
    check({5'h00, alert_o, alert_oe, voltage_range_select}, 8'h02);
    // every channel mode, random codes, restart mid-reply
    for (int n = 0; n < 8; n++) begin
      m = (n % 4 < 2) ? 0 : n % 4 - 1;
      v = (n == 0) ? 12'hFFF : 12'($urandom);
      c = (n == 0) ? 12'h000 : 12'($urandom);
      cmd_wr(modes[n % 4] | {3'h0, 1'($urandom), 4'h0});
      check({7'h00, voltage_range_select}, {7'h00, cmd[4]});
      adc(1'b0);
      u_master.start_cond();
      u_master.get_byte(b);
      check(b, exp_byte(m, 0, v, c));
      u_master.start_cond();
      for (int k = 0; k < (m == 0 ? 3 : 2); k++) begin
        u_master.get_byte(b);
        check(b, exp_byte(m, k, v, c));
      end
    end
    // threshold write, then an unmapped select that must change nothing
    r = 8'($urandom);
    u_master.ext_write(2'h2, r);
    u_master.ext_write(2'h0, ~r);
    check(alert_threshold, r);
    // short comparator pulse is filtered, long one trips
    comparator_overcurrent = 1'b1;
    tick(2);
    comparator_overcurrent = 1'b0;
    tick(12);
    check({7'h00, alert_oe}, 8'h01);
    comparator_overcurrent = 1'b1;
    tick(FD + 12);
    check({7'h00, alert_oe}, 8'h00);
    st_chk(8'h0C);
    // three over-threshold conversions with single-conversion trip enabled
    u_master.ext_write(2'h1, 8'h05);
    repeat (3) adc(1'b1);
    st_chk(8'h0F);
    // force-off with off-alert enabled, then enable removed
    u_master.ext_write(2'h1, 8'h0D);
    u_master.ext_write(2'h3, 8'h01);
    tick(6);
    check({7'h00, alert_oe}, 8'h01);
    st_chk(8'h3F);
    u_master.ext_write(2'h1, 8'h05);
    tick(6);
    check({7'h00, alert_oe}, 8'h00);
    // causes gone, clear latches
    comparator_overcurrent = 1'b0;
    adc(1'b0);
    tick(8);
    u_master.ext_write(2'h1, 8'h15);
    u_master.ext_write(2'h3, 8'h00);
    tick(6);
    check({7'h00, alert_oe}, 8'h01);
    st_chk(8'h00);
    finish_test();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #300000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
